//--- src/fwg_pkg.sv
// Shared constants and types for the flash write guard and chip erase logic
package fwg_pkg;

  // ----------------------------------------------------------------
  // Command opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_WR_EN = 8'h06;
  localparam logic [7:0] OP_WR_DIS = 8'h04;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'h62;
  localparam logic [7:0] OP_CHIP_ERASE_C = 8'hC7;
  localparam logic [7:0] OP_STATUS_WR = 8'h01;
  localparam logic [7:0] OP_PROGRAM = 8'h02;
  localparam logic [7:0] OP_PAGE_ERASE = 8'h81;
  localparam logic [7:0] OP_BLK_ERASE_4K = 8'h20;
  localparam logic [7:0] OP_BLK_ERASE_32K_A = 8'h52;
  localparam logic [7:0] OP_BLK_ERASE_32K_B = 8'hD8;
  localparam logic [7:0] OP_OTP_PROGRAM = 8'h9B;

  // ----------------------------------------------------------------
  // Status byte fields and reset values
  // ----------------------------------------------------------------
  localparam int SR_PROTECT_POS = 2;
  localparam int SR_LOCK_POS = 7;
  localparam logic PROTECT_FACTORY = 1'b0;
  localparam logic LOCK_RESET = 1'b0;
  localparam logic LATCH_RESET = 1'b0;
  localparam logic [3:0] SYNC_RESET = 4'hF;
  localparam int SYNC_W = 4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int CHIP_ERASE_TIME_US = 1000;
  localparam int CHIP_ERASE_CYCLES = CHIP_ERASE_TIME_US * CLK_MHZ;

  typedef enum logic {ER_IDLE, ER_RUN} fwg_erase_state_t;

endpackage

//--- src/fwg_sync.sv
// Two-stage synchroniser for pins arriving from outside the clock domain
`timescale 1ns/10ps
module fwg_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] RST = '1
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } fwg_sync_st_t;

  fwg_sync_st_t r_reg;
  fwg_sync_st_t r_next;

  always_comb begin
    r_next = r_reg;
    r_next.s1 = d_in;
    r_next.s2 = r_reg.s1;
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      r_reg <= {RST, RST};
    end else if (ce_in) begin
      r_reg <= r_next;
    end
  end

  assign q_out = r_reg.s2;
endmodule // fwg_sync

//--- src/fwg_erase_timer.sv
// Self-timed erase sequencer with verify failure capture
`timescale 1ns/10ps
module fwg_erase_timer #(
  parameter int CYCLES = fwg_pkg::CHIP_ERASE_CYCLES
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  input wire logic start_in,
  input wire logic fail_in,
  output logic busy_out,
  output logic done_out,
  output logic fail_out
);
  typedef struct packed {
    fwg_pkg::fwg_erase_state_t st;
    logic [31:0] cnt;
    logic fail;
    logic done;
  } fwg_timer_st_t;

  fwg_timer_st_t r_reg;
  fwg_timer_st_t r_next;

  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    case (r_reg.st)
      fwg_pkg::ER_IDLE: begin
        if (start_in) begin
          r_next.st = fwg_pkg::ER_RUN;
          r_next.cnt = 32'(CYCLES - 1);
          r_next.fail = 1'b0;
        end
      end
      fwg_pkg::ER_RUN: begin
        // Verify result of every location is folded in while running
        if (fail_in) begin
          r_next.fail = 1'b1;
        end
        if (r_reg.cnt == 32'h0000_0000) begin
          r_next.st = fwg_pkg::ER_IDLE;
          r_next.done = 1'b1;
        end else begin
          r_next.cnt = r_reg.cnt - 32'h0000_0001;
        end
      end
      default: r_next.st = fwg_pkg::ER_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      r_reg <= '{st: fwg_pkg::ER_IDLE, cnt: 32'h0000_0000, fail: 1'b0, done: 1'b0};
    end else if (ce_in) begin
      r_reg <= r_next;
    end
  end

  assign busy_out = (r_reg.st == fwg_pkg::ER_RUN);
  assign done_out = r_reg.done;
  assign fail_out = r_reg.fail;
endmodule // fwg_erase_timer

//--- src/fwg_guard.sv
// Write latch, array protection, hardware lock and chip erase command logic
`timescale 1ns/10ps
module fwg_guard #(
  parameter int ERASE_CYCLES = fwg_pkg::CHIP_ERASE_CYCLES
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  input wire logic cs_n_in,
  input wire logic sck_in,
  input wire logic si_in,
  input wire logic wp_n_in,
  input wire logic erase_fail_in,
  input wire logic nv_protect_in,
  output logic write_latch_out,
  output logic array_protect_bit_out,
  output logic protect_lock_bit_out,
  output logic erase_program_error_flag_out,
  output logic busy_out,
  output logic erase_done_out,
  output logic hw_lock_out,
  output logic nv_protect_wr_out,
  output logic nv_protect_data_out,
  output logic array_write_go_out,
  output logic [7:0] array_write_op_out
);

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [3:0] pins_s;
  logic cs_n_s;
  logic sck_s;
  logic si_s;
  logic wp_n_s;

  fwg_sync #(.W(fwg_pkg::SYNC_W), .RST(fwg_pkg::SYNC_RESET)) u_sync (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .d_in({cs_n_in, sck_in, si_in, wp_n_in}),
    .q_out(pins_s)
  );

  assign cs_n_s = pins_s[3];
  assign sck_s = pins_s[2];
  assign si_s = pins_s[1];
  assign wp_n_s = pins_s[0];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cs_q;
    logic sck_q;
    logic [7:0] shift;
    logic [2:0] bit_mod;
    logic [1:0] bytes;
    logic [7:0] opcode;
    logic [7:0] sr_data;
    logic latch;
    logic prot;
    logic lock;
    logic err;
    logic nv_loaded;
    logic nv_wr;
    logic go;
    logic [7:0] go_op;
  } fwg_guard_st_t;

  fwg_guard_st_t r_reg;
  fwg_guard_st_t r_next;

  logic sck_rise;
  logic cs_fall;
  logic frame_end;
  logic frame_full;
  logic is_chip_erase;
  logic hw_lock;
  logic er_start;
  logic er_busy;
  logic er_done;
  logic er_fail;
  logic [7:0] byte_in;

  assign sck_rise = sck_s && !r_reg.sck_q;
  assign cs_fall = !cs_n_s && r_reg.cs_q;
  assign frame_end = cs_n_s && !r_reg.cs_q;
  assign byte_in = {r_reg.shift[6:0], si_s};
  // Whole opcode present and select released on a byte boundary
  assign frame_full = (r_reg.bytes != 2'h0) && (r_reg.bit_mod == 3'h0);
  assign is_chip_erase = (r_reg.opcode == fwg_pkg::OP_CHIP_ERASE_A) ||
                         (r_reg.opcode == fwg_pkg::OP_CHIP_ERASE_B) ||
                         (r_reg.opcode == fwg_pkg::OP_CHIP_ERASE_C);
  // Pin reaches protection only through this term
  assign hw_lock = !wp_n_s && r_reg.lock;

  // ----------------------------------------------------------------
  // Erase sequencer
  // ----------------------------------------------------------------
  fwg_erase_timer #(.CYCLES(ERASE_CYCLES)) u_timer (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .start_in(er_start),
    .fail_in(erase_fail_in),
    .busy_out(er_busy),
    .done_out(er_done),
    .fail_out(er_fail)
  );

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    er_start = 1'b0;
    r_next.cs_q = cs_n_s;
    r_next.sck_q = sck_s;
    r_next.nv_wr = 1'b0;
    r_next.go = 1'b0;
    // Stored protect value is restored once after reset
    if (!r_reg.nv_loaded) begin
      r_next.prot = nv_protect_in;
      r_next.nv_loaded = 1'b1;
    end
    if (cs_fall) begin
      r_next.bit_mod = 3'h0;
      r_next.bytes = 2'h0;
    end else if (!cs_n_s && sck_rise) begin
      r_next.shift = byte_in;
      r_next.bit_mod = r_reg.bit_mod + 3'h1;
      if (r_reg.bit_mod == 3'h7) begin
        if (r_reg.bytes == 2'h0) begin
          r_next.opcode = byte_in;
        end else if (r_reg.bytes == 2'h1) begin
          r_next.sr_data = byte_in;
        end
        // Later bytes are simply dropped
        if (r_reg.bytes != 2'h3) begin
          r_next.bytes = r_reg.bytes + 2'h1;
        end
      end
    end
    // Nothing is accepted while the array is busy erasing
    if (frame_end && !er_busy) begin
      if (frame_full) begin
        case (r_reg.opcode)
          fwg_pkg::OP_WR_EN: r_next.latch = 1'b1;
          fwg_pkg::OP_WR_DIS: r_next.latch = 1'b0;
          fwg_pkg::OP_CHIP_ERASE_A,
          fwg_pkg::OP_CHIP_ERASE_B,
          fwg_pkg::OP_CHIP_ERASE_C: begin
            if (r_reg.prot) begin
              r_next.latch = 1'b0;
            end else if (r_reg.latch) begin
              er_start = 1'b1;
              r_next.latch = 1'b0;
              r_next.err = 1'b0;
            end
          end
          fwg_pkg::OP_STATUS_WR: begin
            // Status write with the data byte, latch set and no hardware lock
            if (r_reg.bytes >= 2'h2 && r_reg.latch && !hw_lock) begin
              r_next.latch = 1'b0;
              r_next.prot = r_reg.sr_data[fwg_pkg::SR_PROTECT_POS];
              r_next.lock = r_reg.sr_data[fwg_pkg::SR_LOCK_POS];
              r_next.nv_wr = 1'b1;
            end
          end
          fwg_pkg::OP_PROGRAM,
          fwg_pkg::OP_PAGE_ERASE,
          fwg_pkg::OP_BLK_ERASE_4K,
          fwg_pkg::OP_BLK_ERASE_32K_A,
          fwg_pkg::OP_BLK_ERASE_32K_B: begin
            if (r_reg.latch && !r_reg.prot) begin
              r_next.go = 1'b1;
              r_next.go_op = r_reg.opcode;
            end
          end
          fwg_pkg::OP_OTP_PROGRAM: begin
            if (r_reg.latch) begin
              r_next.go = 1'b1;
              r_next.go_op = r_reg.opcode;
            end
          end
          default: ;
        endcase
      end else if (r_reg.bytes != 2'h0 && is_chip_erase) begin
        // Erase opcode arrived but select rose mid-byte
        r_next.latch = 1'b0;
      end
    end
    if (er_done && er_fail) begin
      r_next.err = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      r_reg <= '{
        cs_q: 1'b1, sck_q: 1'b1, shift: 8'h00, bit_mod: 3'h0, bytes: 2'h0,
        opcode: 8'h00, sr_data: 8'h00, latch: fwg_pkg::LATCH_RESET,
        prot: fwg_pkg::PROTECT_FACTORY, lock: fwg_pkg::LOCK_RESET,
        err: 1'b0, nv_loaded: 1'b0, nv_wr: 1'b0, go: 1'b0, go_op: 8'h00
      };
    end else if (ce_in) begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign write_latch_out = r_reg.latch;
  assign array_protect_bit_out = r_reg.prot;
  assign protect_lock_bit_out = r_reg.lock;
  assign erase_program_error_flag_out = r_reg.err;
  // Busy is what the host polls for completion
  assign busy_out = er_busy;
  assign erase_done_out = er_done;
  assign hw_lock_out = hw_lock;
  assign nv_protect_wr_out = r_reg.nv_wr;
  assign nv_protect_data_out = r_reg.prot;
  assign array_write_go_out = r_reg.go;
  assign array_write_op_out = r_reg.go_op;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);

  logic ev;
  assign ev = ce_in && frame_end && !er_busy;

  property p_wr_en;
    ev && frame_full && r_reg.opcode == fwg_pkg::OP_WR_EN |=> r_reg.latch;
  endproperty
  a_wr_en: assert property (p_wr_en) else $error("write enable did not set latch");

  property p_wr_dis;
    ev && frame_full && r_reg.opcode == fwg_pkg::OP_WR_DIS |=> !r_reg.latch;
  endproperty
  a_wr_dis: assert property (p_wr_dis) else $error("write disable did not clear latch");

  property p_partial_keep;
    ce_in && frame_end && !frame_full && !is_chip_erase |=> $stable(r_reg.latch);
  endproperty
  a_partial_keep: assert property (p_partial_keep) else $error("partial frame changed latch");

  property p_partial_no_erase;
    ce_in && frame_end && !frame_full |=> !$rose(er_busy);
  endproperty
  a_partial_no_erase: assert property (p_partial_no_erase) else $error("partial frame erased");

  property p_erase_go;
    ev && frame_full && is_chip_erase && r_reg.latch && !r_reg.prot |=> er_busy && !r_reg.latch;
  endproperty
  a_erase_go: assert property (p_erase_go) else $error("accepted erase did not start");

  property p_protected;
    ev && frame_full && is_chip_erase && r_reg.prot |=> !$rose(er_busy) && !r_reg.latch;
  endproperty
  a_protected: assert property (p_protected) else $error("protected array erased");

  property p_busy_latch;
    $rose(er_busy) |-> !r_reg.latch;
  endproperty
  a_busy_latch: assert property (p_busy_latch) else $error("latch set while erasing");

  property p_err_flag;
    ce_in && er_done && er_fail |=> r_reg.err;
  endproperty
  a_err_flag: assert property (p_err_flag) else $error("erase failure not flagged");

  property p_hw_lock;
    ev && frame_full && r_reg.opcode == fwg_pkg::OP_STATUS_WR && !wp_n_s && r_reg.lock
      |=> $stable(r_reg.prot) && $stable(r_reg.lock);
  endproperty
  a_hw_lock: assert property (p_hw_lock) else $error("locked bits changed");

  property p_sr_needs_latch;
    ev && r_reg.opcode == fwg_pkg::OP_STATUS_WR && !r_reg.latch |=> $stable(r_reg.prot);
  endproperty
  a_sr_needs_latch: assert property (p_sr_needs_latch) else $error("status write without latch");

  property p_sr_write;
    ev && frame_full && r_reg.opcode == fwg_pkg::OP_STATUS_WR && r_reg.bytes >= 2'h2 && r_reg.latch && !hw_lock
      |=> r_reg.nv_wr && !r_reg.latch;
  endproperty
  a_sr_write: assert property (p_sr_write) else $error("status write not executed");

  property p_protect_blocks;
    ev && frame_full && r_reg.prot && r_reg.opcode == fwg_pkg::OP_PROGRAM |=> !r_reg.go;
  endproperty
  a_protect_blocks: assert property (p_protect_blocks) else $error("protected array accepted program");

  property p_go_needs_latch;
    ev && !r_reg.latch |=> !r_reg.go;
  endproperty
  a_go_needs_latch: assert property (p_go_needs_latch) else $error("array write without latch");

  property p_misaligned_erase;
    ev && !frame_full && r_reg.bytes != 2'h0 && is_chip_erase |=> !r_reg.latch && !er_busy;
  endproperty
  a_misaligned_erase: assert property (p_misaligned_erase) else $error("misaligned erase kept latch");

  c_erase: cover property (ev && frame_full && is_chip_erase && r_reg.latch && !r_reg.prot);
  c_erase_done: cover property (er_done && er_fail);
  c_locked_write: cover property (ev && r_reg.opcode == fwg_pkg::OP_STATUS_WR && hw_lock);
  c_misaligned: cover property (ce_in && frame_end && !frame_full && r_reg.bytes != 2'h0);
  c_sr_write: cover property (ev && frame_full && r_reg.opcode == fwg_pkg::OP_STATUS_WR && r_reg.latch);

endmodule // fwg_guard

//--- verification/fwg_host_model.sv
// Host-side SPI controller model that frames flash commands
`timescale 1ns/10ps
module fwg_host_model (
  input wire logic clk_in,
  output logic cs_n_out,
  output logic sck_out,
  output logic si_out
);
  // Mode 0: clock rests low and select idles high between frames
  initial begin
    cs_n_out = 1'b1;
    sck_out = 1'b0;
    si_out = 1'b0;
  end

  // ------------------------------------------------------------
  // Frame of n bits taken from the top of d, MSB first
  // ------------------------------------------------------------
  // Each phase is 4 clocks (160 ns period), above the 3-clock minimum
  task automatic send(input logic [39:0] d, input int n);
    int i;
    @(negedge clk_in);
    cs_n_out = 1'b0;
    for (i = 0; i < n; i++) begin
      si_out = d[39-i];
      repeat (4) @(negedge clk_in);
      sck_out = 1'b1;
      repeat (4) @(negedge clk_in);
      sck_out = 1'b0;
    end
    repeat (4) @(negedge clk_in);
    cs_n_out = 1'b1;
    // Released data line must not keep showing the last bit
    si_out = ~si_out;
    repeat (6) @(negedge clk_in);
  endtask
endmodule // fwg_host_model

//--- verification/fwg_guard_bench.sv
// Self-checking bench for the write guard and chip erase logic
`timescale 1ns/10ps
module fwg_guard_bench;
  localparam int ERASE_N = 200;
  logic clk_in, nrst_in, wp_n, efail, nvp;
  logic cs_n, sck, si;
  logic latch, prot, lock, err, busy, done, hwl, nvwr, nvd, go;
  logic [7:0] op_seen;
  logic m_latch, m_prot, m_lock, m_err;
  int err_total, compares, n_done, n_go, n_nvwr, i;
  logic [7:0] ops [4] = '{8'h06, 8'h04, 8'h06, 8'h04};
  logic [7:0] ers [3] = '{fwg_pkg::OP_CHIP_ERASE_A, fwg_pkg::OP_CHIP_ERASE_B, fwg_pkg::OP_CHIP_ERASE_C};

  fwg_guard #(.ERASE_CYCLES(ERASE_N)) i_fwg_guard (
    .clk_in(clk_in), .nrst_in(nrst_in), .ce_in(1'b1), .cs_n_in(cs_n), .sck_in(sck), .si_in(si),
    .wp_n_in(wp_n), .erase_fail_in(efail), .nv_protect_in(nvp), .write_latch_out(latch),
    .array_protect_bit_out(prot), .protect_lock_bit_out(lock), .erase_program_error_flag_out(err),
    .busy_out(busy), .erase_done_out(done), .hw_lock_out(hwl), .nv_protect_wr_out(nvwr),
    .nv_protect_data_out(nvd), .array_write_go_out(go), .array_write_op_out(op_seen));

  fwg_host_model i_fwg_host_model (.clk_in(clk_in), .cs_n_out(cs_n), .sck_out(sck), .si_out(si));

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  // Pulse counters; sampled mid-cycle so the launching edge cannot race them
  always @(negedge clk_in) begin
    if (done === 1'b1) n_done++;
    if (go === 1'b1) n_go++;
    if (nvwr === 1'b1) n_nvwr++;
  end

  // ------------------------------------------------------------
  // Checking and closing
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  function automatic logic is_erase(input logic [7:0] op);
    return op == ers[0] || op == ers[1] || op == ers[2];
  endfunction

  task automatic do_reset(input logic nv);
    @(negedge clk_in);
    nrst_in = 1'b0;
    nvp = nv;
    repeat (8) @(negedge clk_in);
    nrst_in = 1'b1;
    repeat (4) @(negedge clk_in);
    m_latch = 1'b0;
    m_prot = nv;
    m_lock = 1'b0;
    m_err = 1'b0;
    chk(latch, 1'b0, "rst latch");
    chk(prot, nv, "rst protect");
    chk(lock, 1'b0, "rst lock");
    chk(busy, 1'b0, "rst busy");
  endtask

  // ------------------------------------------------------------
  // One frame plus the expected effect worked out here
  // ------------------------------------------------------------
  task automatic frame(input logic [39:0] d, input int n);
    logic [7:0] op;
    logic ok, was_busy, started, exp_go, exp_wr;
    int g0, w0;
    op = d[39:32];
    ok = n >= 8 && n % 8 == 0;
    was_busy = busy;
    started = 1'b0;
    exp_go = 1'b0;
    exp_wr = 1'b0;
    g0 = n_go;
    w0 = n_nvwr;
    i_fwg_host_model.send(d, n);
    if (!was_busy && ok) begin
      case (op)
        fwg_pkg::OP_WR_EN: m_latch = 1'b1;
        fwg_pkg::OP_WR_DIS: m_latch = 1'b0;
        fwg_pkg::OP_PROGRAM: exp_go = m_latch && !m_prot && n >= 40;
        fwg_pkg::OP_STATUS_WR: if (m_latch && n >= 16 && !(!wp_n && m_lock)) begin
          m_prot = d[24 + fwg_pkg::SR_PROTECT_POS];
          m_lock = d[24 + fwg_pkg::SR_LOCK_POS];
          m_latch = 1'b0;
          exp_wr = 1'b1;
        end
        default: if (is_erase(op) && m_latch) begin
          started = !m_prot;
          m_latch = 1'b0;
          if (started) m_err = 1'b0;
        end
      endcase
    end else if (!was_busy && n >= 8 && is_erase(op)) begin
      m_latch = 1'b0;
    end
    chk(latch, m_latch, "latch");
    chk(prot, m_prot, "protect");
    chk(nvd, m_prot, "nv data");
    chk(lock, m_lock, "lock");
    chk(hwl, !wp_n && m_lock, "hw lock");
    chk(err, m_err, "error flag");
    chk(8'(n_go - g0), 8'(exp_go), "go pulse");
    chk(8'(n_nvwr - w0), 8'(exp_wr), "nv store");
    if (exp_go) chk(op_seen, fwg_pkg::OP_PROGRAM, "go op");
    if (!was_busy) chk(busy, started, "busy");
  endtask

  task automatic finish_erase(input logic fail);
    int k, d0;
    d0 = n_done;
    if (fail) begin
      @(negedge clk_in);
      efail = 1'b1;
      @(negedge clk_in);
      efail = 1'b0;
    end
    // Poll busy rather than sit out the whole erase time
    for (k = 0; k < ERASE_N + 50 && busy !== 1'b0; k++) @(negedge clk_in);
    if (busy !== 1'b0) begin
      err_total++;
      $display("CHECK FAILED t=%0t erase never ended", $time);
      conclude();
    end
    repeat (2) @(negedge clk_in);
    m_err = fail;
    chk(8'(n_done - d0), 8'h01, "done pulse");
    chk(err, m_err, "error flag");
    chk(latch, 1'b0, "latch after erase");
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    nrst_in = 1'b0;
    wp_n = 1'b1;
    efail = 1'b0;
    nvp = 1'b0;
    err_total = 0;
    compares = 0;
    n_done = 0;
    n_go = 0;
    n_nvwr = 0;
    void'($urandom(89678));
    do_reset(1'b1);
    frame({fwg_pkg::OP_WR_EN, 32'h0}, 7);
    frame({fwg_pkg::OP_WR_EN, 8'($urandom), 24'h0}, 16);
    frame({fwg_pkg::OP_WR_DIS, 32'h0}, 12);
    frame({fwg_pkg::OP_WR_DIS, 32'h0}, 8);
    repeat (8) frame({ops[$urandom % 4], 32'($urandom)}, 4 * (1 + $urandom % 4));
    $display("test latch commands done");
    frame({fwg_pkg::OP_WR_EN, 32'h0}, 8);
    frame({fwg_pkg::OP_STATUS_WR, 8'h00, 24'h0}, 16);
    for (i = 0; i < 3; i++) begin
      frame({fwg_pkg::OP_WR_EN, 32'h0}, 8);
      frame({ers[i], 8'($urandom), 24'h0}, 8 * (1 + $urandom % 2));
      if (i == 0) frame({fwg_pkg::OP_WR_EN, 32'h0}, 8);
      finish_erase(i == 1);
    end
    $display("test chip erase done");
    frame({fwg_pkg::OP_CHIP_ERASE_C, 32'h0}, 8);
    frame({fwg_pkg::OP_WR_EN, 32'h0}, 8);
    frame({fwg_pkg::OP_CHIP_ERASE_C, 32'h0}, 12);
    frame({fwg_pkg::OP_WR_EN, 32'h0}, 8);
    frame({fwg_pkg::OP_CHIP_ERASE_A, 32'h0}, 5);
    frame({fwg_pkg::OP_PROGRAM, 32'($urandom)}, 40);
    frame({fwg_pkg::OP_WR_DIS, 32'h0}, 8);
    frame({fwg_pkg::OP_PROGRAM, 32'($urandom)}, 40);
    $display("test rejections done");
    frame({fwg_pkg::OP_WR_EN, 32'h0}, 8);
    frame({fwg_pkg::OP_STATUS_WR, 8'h04, 24'h0}, 16);
    frame({fwg_pkg::OP_WR_EN, 32'h0}, 8);
    frame({fwg_pkg::OP_CHIP_ERASE_B, 32'h0}, 8);
    frame({fwg_pkg::OP_WR_EN, 32'h0}, 8);
    frame({fwg_pkg::OP_PROGRAM, 32'($urandom)}, 40);
    $display("test protection done");
    @(negedge clk_in);
    wp_n = 1'b0;
    frame({fwg_pkg::OP_WR_EN, 32'h0}, 8);
    frame({fwg_pkg::OP_STATUS_WR, 8'h84, 24'h0}, 16);
    frame({fwg_pkg::OP_WR_EN, 32'h0}, 8);
    frame({fwg_pkg::OP_STATUS_WR, 8'h00, 24'h0}, 16);
    @(negedge clk_in);
    wp_n = 1'b1;
    frame({fwg_pkg::OP_STATUS_WR, 8'h00, 24'h0}, 16);
    frame({fwg_pkg::OP_WR_EN, 32'h0}, 8);
    frame({fwg_pkg::OP_STATUS_WR, 8'h84, 24'h0}, 16);
    frame({fwg_pkg::OP_WR_EN, 32'h0}, 8);
    frame({fwg_pkg::OP_STATUS_WR, 8'h80, 24'h0}, 16);
    @(negedge clk_in);
    wp_n = 1'b0;
    frame({fwg_pkg::OP_WR_DIS, 32'h0}, 8);
    do_reset(1'b0);
    $display("test hardware lock done");
    conclude();
  end
endmodule // fwg_guard_bench
